// ===== pep_host.sv
/*
 * host-side sequencer for a byte-wide parallel eeprom: read, byte write,
 * page write from a buffer, protection command, write-end wait or polling.
 * assumes one eeprom on the pins and data_pins inputs synchronous to clk.
 */
// Functional notes
// - without polling wait full write time
// - page byte loads 1 to 100 us apart
// - each page load uses single write timing
// - hold write strobe high 1 us after protection
// - output enable only pulsed outside byte loads
// - polling uses ordinary read cycle timing
// - wait after power-up before accessing
`timescale 1ns/100ps
`default_nettype none
module pep_host #(
	parameter int WC_CYC = pep_pkg::WC_CYC,
	parameter int PUW_CYC = pep_pkg::PUW_CYC
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire pep_pkg::pep_op_t cmd_op,
	input wire logic [pep_pkg::ADDR_W-1:0] cmd_addr,
	input wire logic [pep_pkg::DATA_W-1:0] cmd_wdata,
	input wire logic [pep_pkg::PAGE_W-1:0] cmd_last,
	input wire logic cmd_poll,
	input wire logic buf_wr,
	input wire logic [pep_pkg::PAGE_W-1:0] buf_addr,
	input wire logic [pep_pkg::DATA_W-1:0] buf_wdata,
	output logic rsp_valid,
	output logic [pep_pkg::DATA_W-1:0] rsp_rdata,
	output logic rsp_timeout,
	output logic busy,
	output logic [pep_pkg::ADDR_W-1:0] address_pins,
	output logic ce_n,
	output logic oe_n,
	output logic we_n,
	input wire logic [pep_pkg::DATA_W-1:0] data_pins_in,
	output logic [pep_pkg::DATA_W-1:0] data_pins_out,
	output logic data_pins_oe
);
	localparam int CW = pep_pkg::CNT_W;

	// ----------------------------------------------------------------
	// page buffer
	// ----------------------------------------------------------------
	pep_page_if pg_bus ();
	logic [pep_pkg::PAGE_W-1:0] idx_ff, nxt_idx;

	assign pg_bus.wr_en = buf_wr;
	assign pg_bus.wr_addr = buf_addr;
	assign pg_bus.wr_data = buf_wdata;
	assign pg_bus.rd_addr = idx_ff;

	pep_page_mem pep_page_mem_inst (.clk(clk), .rstn(rstn), .pg(pg_bus.mem));

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	pep_pkg::pep_state_t state_ff, nxt_state;
	pep_pkg::pep_op_t op_ff, nxt_op;
	logic [CW-1:0] cnt_ff, nxt_cnt, wc_ff, nxt_wc;
	logic [pep_pkg::ADDR_W-1:0] base_ff, nxt_base, addr_ff, nxt_addr;
	logic [pep_pkg::DATA_W-1:0] wdata_ff, nxt_wdata, dout_ff, nxt_dout, rdata_ff, nxt_rdata;
	logic [pep_pkg::PAGE_W-1:0] last_ff, nxt_last;
	logic poll_ff, nxt_poll, polling_ff, nxt_polling, bit7_ff, nxt_bit7;
	logic ce_n_ff, nxt_ce_n, oe_n_ff, nxt_oe_n, we_n_ff, nxt_we_n, doe_ff, nxt_doe;
	logic ready_ff, nxt_ready, rsp_ff, nxt_rsp, tmo_ff, nxt_tmo, busy_ff, nxt_busy;

	function automatic logic at(input logic [CW-1:0] c, input int n);
		return c == CW'(n - 1);
	endfunction : at

	always_comb begin
		nxt_state = state_ff;
		nxt_op = op_ff;
		nxt_cnt = cnt_ff + 1'b1;
		nxt_wc = polling_ff ? wc_ff + 1'b1 : '0;
		nxt_base = base_ff;
		nxt_addr = addr_ff;
		nxt_wdata = wdata_ff;
		nxt_dout = dout_ff;
		nxt_rdata = rdata_ff;
		nxt_last = last_ff;
		nxt_idx = idx_ff;
		nxt_poll = poll_ff;
		nxt_polling = polling_ff;
		nxt_bit7 = bit7_ff;
		nxt_ce_n = ce_n_ff;
		nxt_oe_n = oe_n_ff;
		nxt_we_n = we_n_ff;
		nxt_doe = doe_ff;
		nxt_ready = ready_ff;
		nxt_rsp = 1'b0;
		nxt_tmo = tmo_ff;
		nxt_busy = busy_ff;
		unique case (state_ff)
			pep_pkg::ST_PWR: begin
				if (at(cnt_ff, PUW_CYC)) begin
					nxt_state = pep_pkg::ST_IDLE;
					nxt_ready = 1'b1;
					nxt_busy = 1'b0;
				end
			end
			pep_pkg::ST_IDLE: begin
				nxt_cnt = '0;
				if (cmd_valid && ready_ff) begin
					nxt_ready = 1'b0;
					nxt_busy = 1'b1;
					nxt_tmo = 1'b0;
					nxt_op = cmd_op;
					nxt_base = cmd_addr;
					nxt_wdata = cmd_wdata;
					nxt_poll = cmd_poll;
					nxt_idx = '0;
					nxt_last = (cmd_op == pep_pkg::OP_PAGE) ? cmd_last :
						(cmd_op == pep_pkg::OP_PROTECT) ? pep_pkg::PROT_LAST : '0;
					if (cmd_op == pep_pkg::OP_READ) begin
						nxt_addr = cmd_addr;
						nxt_ce_n = 1'b0;
						nxt_oe_n = 1'b0;
						nxt_state = pep_pkg::ST_RD_ACC;
					end else begin
						nxt_state = pep_pkg::ST_FETCH;
					end
				end
			end
			pep_pkg::ST_FETCH: begin
				// buffer read data is valid on the second cycle
				if (cnt_ff != '0) begin
					unique case (op_ff)
						pep_pkg::OP_PAGE: begin
							nxt_addr = {base_ff[pep_pkg::ADDR_W-1:pep_pkg::PAGE_W],
								base_ff[pep_pkg::PAGE_W-1:0] + idx_ff};
							nxt_dout = pg_bus.rd_data;
						end
						pep_pkg::OP_PROTECT: begin
							nxt_addr = pep_pkg::PROT_ADDR[idx_ff[1:0]];
							nxt_dout = pep_pkg::PROT_DATA[idx_ff[1:0]];
						end
						default: begin
							nxt_addr = base_ff;
							nxt_dout = wdata_ff;
						end
					endcase
					nxt_ce_n = 1'b0;
					nxt_oe_n = 1'b1;
					nxt_doe = 1'b1;
					nxt_state = pep_pkg::ST_WR_SET;
				end
			end
			pep_pkg::ST_WR_SET: begin
				nxt_we_n = 1'b0;
				nxt_cnt = '0;
				nxt_state = pep_pkg::ST_WR_LOW;
			end
			pep_pkg::ST_WR_LOW: begin
				if (at(cnt_ff, pep_pkg::WP_CYC)) begin
					nxt_we_n = 1'b1;
					nxt_cnt = '0;
					nxt_state = pep_pkg::ST_WR_REC;
				end
			end
			pep_pkg::ST_WR_REC: begin
				if (at(cnt_ff, pep_pkg::WPH_CYC)) begin
					nxt_ce_n = 1'b1;
					nxt_doe = 1'b0;
					nxt_bit7 = dout_ff[pep_pkg::MSB];
					nxt_cnt = '0;
					if (idx_ff != last_ff) begin
						nxt_idx = idx_ff + 1'b1;
						nxt_state = pep_pkg::ST_GAP;
					end else if (op_ff == pep_pkg::OP_PROTECT) begin
						nxt_state = pep_pkg::ST_PROT_REC;
					end else if (poll_ff) begin
						nxt_polling = 1'b1;
						nxt_state = pep_pkg::ST_TURN;
					end else begin
						nxt_state = pep_pkg::ST_WAIT_WC;
					end
				end
			end
			pep_pkg::ST_GAP: begin
				// oe_n stays high between loads so the open page is untouched
				if (at(cnt_ff, pep_pkg::BLC_MIN_CYC)) begin
					nxt_cnt = '0;
					nxt_state = pep_pkg::ST_FETCH;
				end
			end
			pep_pkg::ST_TURN: begin
				// one idle cycle so host and device never drive together
				nxt_ce_n = 1'b0;
				nxt_oe_n = 1'b0;
				nxt_cnt = '0;
				nxt_state = pep_pkg::ST_RD_ACC;
			end
			pep_pkg::ST_RD_ACC: begin
				if (at(cnt_ff, pep_pkg::RC_CYC)) begin
					nxt_rdata = data_pins_in;
					nxt_ce_n = 1'b1;
					nxt_oe_n = 1'b1;
					nxt_cnt = '0;
					nxt_state = pep_pkg::ST_FLOAT;
				end
			end
			pep_pkg::ST_FLOAT: begin
				if (at(cnt_ff, pep_pkg::HZ_CYC)) begin
					nxt_cnt = '0;
					// range test: the poll period need not divide the write limit
					if (polling_ff && (rdata_ff[pep_pkg::MSB] != bit7_ff) &&
						(wc_ff < CW'(WC_CYC - 1))) begin
						nxt_ce_n = 1'b0;
						nxt_oe_n = 1'b0;
						nxt_state = pep_pkg::ST_RD_ACC;
					end else begin
						nxt_tmo = polling_ff && (rdata_ff[pep_pkg::MSB] != bit7_ff);
						nxt_polling = 1'b0;
						nxt_rsp = 1'b1;
						nxt_ready = 1'b1;
						nxt_busy = 1'b0;
						nxt_state = pep_pkg::ST_IDLE;
					end
				end
			end
			pep_pkg::ST_WAIT_WC, pep_pkg::ST_PROT_REC: begin
				if ((state_ff == pep_pkg::ST_WAIT_WC && at(cnt_ff, WC_CYC)) ||
					(state_ff == pep_pkg::ST_PROT_REC && at(cnt_ff, pep_pkg::WPH2_CYC))) begin
					nxt_rsp = 1'b1;
					nxt_ready = 1'b1;
					nxt_busy = 1'b0;
					nxt_state = pep_pkg::ST_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_ff <= pep_pkg::ST_PWR;
			op_ff <= pep_pkg::OP_READ;
			cnt_ff <= '0;
			wc_ff <= '0;
			base_ff <= 15'h0000;
			addr_ff <= 15'h0000;
			wdata_ff <= 8'h00;
			dout_ff <= 8'h00;
			rdata_ff <= 8'h00;
			last_ff <= 6'h00;
			idx_ff <= 6'h00;
			poll_ff <= 1'b0;
			polling_ff <= 1'b0;
			bit7_ff <= 1'b0;
			ce_n_ff <= 1'b1;
			oe_n_ff <= 1'b1;
			we_n_ff <= 1'b1;
			doe_ff <= 1'b0;
			ready_ff <= 1'b0;
			rsp_ff <= 1'b0;
			tmo_ff <= 1'b0;
			busy_ff <= 1'b1;
		end else begin
			state_ff <= nxt_state;
			op_ff <= nxt_op;
			cnt_ff <= nxt_cnt;
			wc_ff <= nxt_wc;
			base_ff <= nxt_base;
			addr_ff <= nxt_addr;
			wdata_ff <= nxt_wdata;
			dout_ff <= nxt_dout;
			rdata_ff <= nxt_rdata;
			last_ff <= nxt_last;
			idx_ff <= nxt_idx;
			poll_ff <= nxt_poll;
			polling_ff <= nxt_polling;
			bit7_ff <= nxt_bit7;
			ce_n_ff <= nxt_ce_n;
			oe_n_ff <= nxt_oe_n;
			we_n_ff <= nxt_we_n;
			doe_ff <= nxt_doe;
			ready_ff <= nxt_ready;
			rsp_ff <= nxt_rsp;
			tmo_ff <= nxt_tmo;
			busy_ff <= nxt_busy;
		end
	end

	assign cmd_ready = ready_ff;
	assign rsp_valid = rsp_ff;
	assign rsp_rdata = rdata_ff;
	assign rsp_timeout = tmo_ff;
	assign busy = busy_ff;
	assign address_pins = addr_ff;
	assign ce_n = ce_n_ff;
	assign oe_n = oe_n_ff;
	assign we_n = we_n_ff;
	assign data_pins_out = dout_ff;
	assign data_pins_oe = doe_ff;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	logic [11:0] since_fall_ff, we_hi_ff;
	logic prot_done_ff;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			since_fall_ff <= 12'hFFF;
			we_hi_ff <= 12'hFFF;
			prot_done_ff <= 1'b0;
		end else begin
			since_fall_ff <= (nxt_we_n == 1'b0 && we_n_ff) ? 12'h000 :
				(since_fall_ff == 12'hFFF) ? since_fall_ff : since_fall_ff + 1'b1;
			we_hi_ff <= !we_n_ff ? 12'h000 :
				(we_hi_ff == 12'hFFF) ? we_hi_ff : we_hi_ff + 1'b1;
			prot_done_ff <= (state_ff == pep_pkg::ST_PROT_REC) ? 1'b1 :
				(!we_n_ff ? 1'b0 : prot_done_ff);
		end
	end

	chk_write_strobes: assert property (@(posedge clk) disable iff (!rstn)
		!we_n_ff |-> (!ce_n_ff && oe_n_ff && doe_ff))
		else $error("write strobe low without chip select or with oe low");
	chk_no_contention: assert property (@(posedge clk) disable iff (!rstn)
		!oe_n_ff |-> !doe_ff)
		else $error("host drives data while output enable is low");
	chk_float_turn: assert property (@(posedge clk) disable iff (!rstn)
		$rose(oe_n_ff) |-> !doe_ff ##1 !doe_ff)
		else $error("host drove data inside float delay");
	chk_pulse_width: assert property (@(posedge clk) disable iff (!rstn)
		$fell(we_n_ff) |-> !we_n_ff[*2] ##1 (we_n_ff && !ce_n_ff) ##1 ce_n_ff)
		else $error("write pulse width or recovery wrong");
	chk_load_spacing: assert property (@(posedge clk) disable iff (!rstn)
		($fell(we_n_ff) && op_ff == pep_pkg::OP_PAGE && idx_ff != '0) |->
		($past(since_fall_ff) >= 12'(pep_pkg::BLC_MIN_CYC - 1) &&
		$past(since_fall_ff) < 12'(pep_pkg::BLC_MAX_CYC)))
		else $error("page byte load spacing out of window");
	chk_prot_recovery: assert property (@(posedge clk) disable iff (!rstn)
		($fell(we_n_ff) && prot_done_ff) |-> $past(we_hi_ff) >= 12'(pep_pkg::WPH2_CYC))
		else $error("write after protection too early");
	chk_wait_quiet: assert property (@(posedge clk) disable iff (!rstn)
		(state_ff == pep_pkg::ST_WAIT_WC) |-> (ce_n_ff && oe_n_ff && we_n_ff))
		else $error("access started during write time");
	chk_power_quiet: assert property (@(posedge clk) disable iff (!rstn)
		(state_ff == pep_pkg::ST_PWR) |-> (ce_n_ff && !ready_ff))
		else $error("access before power-up wait");
	chk_page_upper: assert property (@(posedge clk) disable iff (!rstn)
		($fell(we_n_ff) && op_ff == pep_pkg::OP_PAGE) |->
		addr_ff[pep_pkg::ADDR_W-1:pep_pkg::PAGE_W] ==
		base_ff[pep_pkg::ADDR_W-1:pep_pkg::PAGE_W])
		else $error("page load left its page");
	chk_read_length: assert property (@(posedge clk) disable iff (!rstn)
		$fell(oe_n_ff) |-> (!oe_n_ff && !ce_n_ff && we_n_ff)[*6] ##1 oe_n_ff)
		else $error("read cycle length wrong");
	chk_poll_end: assert property (@(posedge clk) disable iff (!rstn)
		(rsp_ff && $past(polling_ff) && !tmo_ff) |-> rdata_ff[pep_pkg::MSB] == bit7_ff)
		else $error("poll ended before bit 7 matched");

	cov_read: cover property (@(posedge clk) disable iff (!rstn)
		rsp_ff && op_ff == pep_pkg::OP_READ);
	cov_page: cover property (@(posedge clk) disable iff (!rstn)
		rsp_ff && op_ff == pep_pkg::OP_PAGE && last_ff != '0);
	cov_poll: cover property (@(posedge clk) disable iff (!rstn)
		rsp_ff && $past(polling_ff) && !tmo_ff);
	cov_protect: cover property (@(posedge clk) disable iff (!rstn)
		rsp_ff && op_ff == pep_pkg::OP_PROTECT);
endmodule : pep_host
`default_nettype wire

// ===== pep_pkg.sv
/*
 * constants, timing counts and types for the parallel eeprom host port.
 * assumes a 50 ns system clock; all pin timings are rounded to whole cycles.
 */
package pep_pkg;
	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int ADDR_W = 15;
	localparam int DATA_W = 8;
	localparam int PAGE_W = 6;
	localparam int CNT_W = 24;
	localparam int DEPTH = 64;
	localparam int MSB = 7;

	// ----------------------------------------------------------------
	// timing in printed units
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 50;
	localparam int NS_PER_US = 1000;
	localparam int NS_PER_MS = 1000000;
	localparam int T_RC_NS = 300;
	localparam int T_WP_NS = 100;
	localparam int T_WPH_NS = 50;
	localparam int T_HZ_NS = 50;
	localparam int T_BLC_MIN_US = 1;
	localparam int T_BLC_MAX_US = 100;
	localparam int T_WPH2_US = 1;
	localparam int T_WC_MS = 10;
	localparam int T_WC_TYP_MS = 5;
	localparam int T_PUR_US = 100;
	localparam int T_PUW_MS = 5;

	function automatic int cyc_min(input int t_ns);
		int v;
		v = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (v < 1) ? 1 : v;
	endfunction : cyc_min

	function automatic int cyc_max(input int t_ns);
		int v;
		v = t_ns / CLK_PERIOD_NS;
		return (v < 1) ? 1 : v;
	endfunction : cyc_max

	// ----------------------------------------------------------------
	// cycle counts
	// ----------------------------------------------------------------
	localparam int RC_CYC = cyc_min(T_RC_NS);
	localparam int WP_CYC = cyc_min(T_WP_NS);
	localparam int WPH_CYC = cyc_min(T_WPH_NS);
	localparam int HZ_CYC = cyc_min(T_HZ_NS);
	localparam int BLC_MIN_CYC = cyc_min(T_BLC_MIN_US * NS_PER_US);
	localparam int BLC_MAX_CYC = cyc_max(T_BLC_MAX_US * NS_PER_US);
	localparam int WPH2_CYC = cyc_min(T_WPH2_US * NS_PER_US);
	localparam int WC_CYC = cyc_min(T_WC_MS * NS_PER_MS);
	localparam int PUW_CYC = cyc_min(T_PUW_MS * NS_PER_MS);

	// ----------------------------------------------------------------
	// protection command sequence
	// ----------------------------------------------------------------
	localparam logic [PAGE_W-1:0] PROT_LAST = 6'h02;
	localparam logic [ADDR_W-1:0] PROT_ADDR [3] = '{15'h1111, 15'h2222, 15'h3333};
	localparam logic [DATA_W-1:0] PROT_DATA [3] = '{8'hA1, 8'hA2, 8'hA3};

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {OP_READ, OP_BYTE, OP_PAGE, OP_PROTECT} pep_op_t;

	typedef enum logic [3:0] {
		ST_PWR, ST_IDLE, ST_FETCH, ST_WR_SET, ST_WR_LOW, ST_WR_REC, ST_GAP,
		ST_TURN, ST_RD_ACC, ST_FLOAT, ST_WAIT_WC, ST_PROT_REC
	} pep_state_t;
endpackage : pep_pkg

// ===== pep_page_if.sv
/*
 * page buffer carrier between the host sequencer and its buffer memory.
 * assumes both ends share one clock.
 */
`timescale 1ns/100ps
`default_nettype none
interface pep_page_if;
	logic wr_en;
	logic [pep_pkg::PAGE_W-1:0] wr_addr;
	logic [pep_pkg::DATA_W-1:0] wr_data;
	logic [pep_pkg::PAGE_W-1:0] rd_addr;
	logic [pep_pkg::DATA_W-1:0] rd_data;
	modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
	modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : pep_page_if
`default_nettype wire

// ===== pep_page_mem.sv
/*
 * 64-byte page buffer with registered read data.
 * assumes the writer does not change a slot while a page is being sent.
 */
`timescale 1ns/100ps
`default_nettype none
module pep_page_mem (
	input wire logic clk,
	input wire logic rstn,
	pep_page_if.mem pg
);
	logic [pep_pkg::DATA_W-1:0] mem_ff [pep_pkg::DEPTH];
	logic [pep_pkg::DATA_W-1:0] rd_ff;
	logic [pep_pkg::DATA_W-1:0] nxt_rd;

	always_comb begin
		nxt_rd = mem_ff[pg.rd_addr];
	end

	// array has no reset: contents are only read after being loaded
	always_ff @(posedge clk) begin
		if (pg.wr_en) begin
			mem_ff[pg.wr_addr] <= pg.wr_data;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rd_ff <= 8'h00;
		end else begin
			rd_ff <= nxt_rd;
		end
	end

	assign pg.rd_data = rd_ff;
endmodule : pep_page_mem
`default_nettype wire

// ===== pep_eeprom_model.sv
/*
 * behavioural byte-wide eeprom on the host pins, with a monitor of host timing.
 * assumes registered host strobes on clk; hang stretches the internal write.
 */
`timescale 1ns/100ps
`default_nettype none
module pep_eeprom_model #(
	parameter int PUW = 40,
	parameter int LOAD_WIN = 40,
	parameter int WC = 100
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [pep_pkg::ADDR_W-1:0] address_pins,
	input wire logic ce_n,
	input wire logic oe_n,
	input wire logic we_n,
	input wire logic [pep_pkg::DATA_W-1:0] host_data,
	input wire logic host_oe,
	input wire logic hang,
	output logic [pep_pkg::DATA_W-1:0] data_pins_in,
	output logic [15:0] n_viol
);
	// ----------------------------------------------------------------
	// array, page latch and pins
	// ----------------------------------------------------------------
	logic [7:0] mem [0:32767];
	logic [14:0] pend_a [$];
	logic [7:0] pend_d [$];
	logic [8:0] pg_hi;
	logic [7:0] last_wr, last_bus;
	logic open_pg, tog, we_d, ce_d, oe_d, drive;
	logic [1:0] prot_idx;
	int t, t_load, t_prot, t_we, t_ce, wc_left, v;
	// released bus shows the inverse of its last level, not a held value
	assign drive = !ce_n && !oe_n && we_n && !host_oe;
	assign data_pins_in = host_oe ? host_data : drive ? ((open_pg || wc_left > 0) ?
		{~last_wr[7], tog, last_wr[5:0]} : mem[address_pins]) : ~last_bus;
	// ----------------------------------------------------------------
	// loads, internal write, host timing monitor
	// ----------------------------------------------------------------
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			t = 0;
			t_prot = -100000;
			n_viol <= 16'h0000;
			open_pg <= 1'b0;
			wc_left <= 0;
			tog <= 1'b0;
			prot_idx <= 2'h0;
			we_d <= 1'b1;
			ce_d <= 1'b1;
			oe_d <= 1'b1;
			last_bus <= 8'h00;
		end else begin
			v = 0;
			t = t + 1;
			if (!ce_n && t < PUW) v++;
			if (we_d && !we_n && !ce_n) begin
				if (t - t_prot < pep_pkg::WPH2_CYC) v++;
				if (open_pg && t - t_load < pep_pkg::BLC_MIN_CYC) v++;
				if (wc_left > 0) v++;
				t_we = t;
			end
			if (!we_d && we_n && !ce_n && oe_n) begin
				if (t - t_we < pep_pkg::WP_CYC) v++;
				if (address_pins == pep_pkg::PROT_ADDR[prot_idx] &&
					host_data == pep_pkg::PROT_DATA[prot_idx]) begin
					prot_idx <= (prot_idx == 2'h2) ? 2'h0 : prot_idx + 2'h1;
					if (prot_idx == 2'h2) t_prot = t;
				end else begin
					if (open_pg && address_pins[14:6] != pg_hi) v++;
					pend_a.push_back(address_pins);
					pend_d.push_back(host_data);
					last_wr <= host_data;
					pg_hi <= address_pins[14:6];
					open_pg <= 1'b1;
					t_load = t;
				end
			end
			if (ce_d && !ce_n) t_ce = t;
			if (!ce_d && ce_n && !oe_d) begin
				if (t - t_ce < pep_pkg::RC_CYC) v++;
				if (open_pg || wc_left > 0) tog <= ~tog;
			end
			// page closes once the load window runs out
			if (open_pg && t - t_load > LOAD_WIN) begin
				open_pg <= 1'b0;
				wc_left <= WC;
			end
			if (wc_left > 0 && !hang) begin
				wc_left <= wc_left - 1;
				if (wc_left == 1) begin
					foreach (pend_a[i]) mem[pend_a[i]] <= pend_d[i];
					pend_a.delete();
					pend_d.delete();
				end
			end
			n_viol <= n_viol + 16'(v);
			we_d <= we_n;
			ce_d <= ce_n;
			oe_d <= oe_n;
			last_bus <= data_pins_in;
		end
	end
endmodule : pep_eeprom_model
`default_nettype wire

// ===== pep_host_tb.sv
/*
 * self-checking bench for the eeprom host port against the eeprom model.
 * assumes shortened write and power-up counts; inputs move 1 ns after clk rises.
 */
`timescale 1ns/100ps
`default_nettype none
module pep_host_tb;
	localparam int WC_T = 400;
	localparam int PUW_T = 40;
	logic clk, rstn, cmd_valid, cmd_poll, buf_wr, hang;
	pep_pkg::pep_op_t cmd_op;
	logic [14:0] cmd_addr, address_pins;
	logic [7:0] cmd_wdata, buf_wdata, data_pins_in, data_pins_out, rsp_rdata;
	logic [5:0] cmd_last, buf_addr;
	logic cmd_ready, rsp_valid, rsp_timeout, busy, ce_n, oe_n, we_n, data_pins_oe;
	logic [15:0] n_viol;
	int n_errors, n_compared, n_cyc, lat;
	pep_host #(.WC_CYC(WC_T), .PUW_CYC(PUW_T)) pep_host_inst (.clk, .rstn, .cmd_valid,
		.cmd_ready, .cmd_op, .cmd_addr, .cmd_wdata, .cmd_last, .cmd_poll, .buf_wr,
		.buf_addr, .buf_wdata, .rsp_valid, .rsp_rdata, .rsp_timeout, .busy, .address_pins,
		.ce_n, .oe_n, .we_n, .data_pins_in, .data_pins_out, .data_pins_oe);
	pep_eeprom_model #(.PUW(PUW_T), .LOAD_WIN(40), .WC(100)) pep_eeprom_model_inst (.clk,
		.rstn, .address_pins, .ce_n, .oe_n, .we_n, .host_data(data_pins_out),
		.host_oe(data_pins_oe), .hang, .data_pins_in, .n_viol);
	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic report_and_stop();
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : report_and_stop
	// offers one command, then counts edges from the take to rsp_valid
	task automatic send(input pep_pkg::pep_op_t op, input logic [14:0] a, input logic [7:0] d,
		input logic [5:0] last, input logic poll);
		@(posedge clk);
		#1;
		cmd_op = op;
		cmd_addr = a;
		cmd_wdata = d;
		cmd_last = last;
		cmd_poll = poll;
		cmd_valid = 1'b1;
		do @(posedge clk); while (cmd_ready !== 1'b1);
		#1;
		cmd_valid = 1'b0;
		lat = 0;
		do begin
			@(posedge clk);
			lat++;
		end while (rsp_valid !== 1'b1);
	endtask : send
	task automatic rd(input logic [14:0] a, input logic [7:0] exp);
		send(pep_pkg::OP_READ, a, 8'h00, 6'h00, 1'b0);
		check({8'h00, rsp_rdata}, {8'h00, exp});
		check(16'(lat >= 8 && lat <= 9), 16'h0001);
	endtask : rd
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		int n;
		check({10'h000, ce_n, oe_n, we_n, data_pins_oe, cmd_ready, busy}, 16'h0039);
		#1;
		rstn = 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (cmd_ready !== 1'b1 && n < 1000);
		check(16'(n >= PUW_T && n <= PUW_T + 2), 16'h0001);
		check({15'h0000, busy}, 16'h0000);
		$display("test reset done");
	endtask : t_reset
	task automatic t_byte();
		send(pep_pkg::OP_BYTE, 15'h0123, 8'h5A, 6'h00, 1'b0);
		check(16'(lat > WC_T), 16'h0001);
		rd(15'h0123, 8'h5A);
		send(pep_pkg::OP_BYTE, 15'h0456, 8'hC3, 6'h00, 1'b1);
		check({7'h00, rsp_timeout, rsp_rdata}, 16'h00C3);
		check(16'(lat < WC_T), 16'h0001);
		rd(15'h0456, 8'hC3);
		$display("test byte write done");
	endtask : t_byte
	task automatic t_page();
		int ix[4] = '{0, 58, 59, 63};
		@(posedge clk);
		#1;
		for (int i = 0; i < 64; i++) begin
			buf_wr = 1'b1;
			buf_addr = 6'(i);
			buf_wdata = 8'(i) ^ 8'h3C;
			@(posedge clk);
			#1;
		end
		buf_wr = 1'b0;
		send(pep_pkg::OP_PAGE, 15'h0A85, 8'h00, 6'h3F, 1'b1);
		check({15'h0000, rsp_timeout}, 16'h0000);
		foreach (ix[k]) rd({9'h02A, 6'(5 + ix[k])}, 8'(ix[k]) ^ 8'h3C);
		$display("test page write done");
	endtask : t_page
	task automatic t_protect();
		send(pep_pkg::OP_PROTECT, 15'h0000, 8'h00, 6'h00, 1'b0);
		send(pep_pkg::OP_BYTE, 15'h0789, 8'h66, 6'h00, 1'b0);
		rd(15'h0789, 8'h66);
		$display("test protection done");
	endtask : t_protect
	// the model holds its write open, so polling must give up
	task automatic t_timeout();
		#1;
		hang = 1'b1;
		send(pep_pkg::OP_BYTE, 15'h0321, 8'h81, 6'h00, 1'b1);
		check({14'h0000, rsp_timeout, rsp_rdata[7]}, 16'h0002);
		#1;
		hang = 1'b0;
		repeat (120) @(posedge clk);
		rd(15'h0321, 8'h81);
		$display("test poll timeout done");
	endtask : t_timeout
	// ----------------------------------------------------------------
	// clock, watchdogs, main sequence
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) begin
		n_cyc++;
		if (rstn) check({15'h0000, data_pins_oe & ~oe_n}, 16'h0000);
		if (n_cyc == 20000) begin
			n_errors++;
			report_and_stop();
		end
	end
	initial begin
		rstn = 1'b0;
		cmd_valid = 1'b0;
		cmd_op = pep_pkg::OP_READ;
		cmd_addr = 15'h0000;
		cmd_wdata = 8'h00;
		cmd_last = 6'h00;
		cmd_poll = 1'b0;
		buf_wr = 1'b0;
		buf_addr = 6'h00;
		buf_wdata = 8'h00;
		hang = 1'b0;
		repeat (10) @(posedge clk);
		t_reset();
		t_byte();
		t_page();
		t_protect();
		t_timeout();
		check(n_viol, 16'h0000);
		report_and_stop();
	end
endmodule : pep_host_tb
`default_nettype wire
